/* verilog/astc_seq_ctrl.v */
`timescale 1ns/100ps
`include "astc_consts.vh"

module astc_seq_ctrl (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire [15:0] i_trig_src,
  input  wire [3:0]  i_pwm_mod_sel,
  input  wire [7:0]  i_prio,
  input  wire [3:0]  i_seq_enable,
  input  wire [3:0]  i_phase_delay,
  input  wire        i_ref_sel,
  input  wire [3:0]  i_int_enable,
  input  wire [3:0]  i_dma_int_enable,
  input  wire [3:0]  i_dcmp_int_enable,
  input  wire [3:0]  i_int_clear,
  input  wire [3:0]  i_dma_int_clear,
  input  wire [3:0]  i_dcmp_int_clear,
  input  wire [3:0]  i_proc_trig,
  input  wire        i_proc_trig_wait,
  input  wire        i_proc_sync_signal,
  input  wire        i_status_masked_select,
  input  wire [2:0]  i_cmp_trig,
  input  wire        i_ext_trig,
  input  wire        i_timer_trig,
  input  wire [3:0]  i_pwm_mod0_trig,
  input  wire [3:0]  i_pwm_mod1_trig,
  input  wire [3:0]  i_dma_event,
  input  wire [3:0]  i_dcmp_event,
  output reg  [3:0]  o_phase_delay,
  output reg         o_ref_sel,
  output reg  [3:0]  o_int_raw,
  output reg  [3:0]  o_int_masked,
  output reg  [19:0] o_status,
  output wire        o_irq,
  output reg         o_conv_busy,
  output reg  [1:0]  o_active_seq,
  output reg  [3:0]  o_active_depth,
  output reg  [3:0]  o_seq_start
);

  // ==========================================================
  // Input synchronisers for pin-side triggers
  // ==========================================================
  reg  [20:0] sync1_r;
  reg  [20:0] sync2_r;
  reg  [20:0] sync3_r;
  wire [20:0] pin_in = {i_dma_event, i_dcmp_event, i_pwm_mod1_trig, i_pwm_mod0_trig,
                        i_timer_trig, i_ext_trig, i_cmp_trig};

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= 21'h000000;
      sync2_r <= 21'h000000;
      sync3_r <= 21'h000000;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Rising edges of synchronised triggers
  wire [20:0] pin_rise  = sync2_r & ~sync3_r;
  wire [2:0]  cmp_rise  = pin_rise[2:0];
  wire        ext_rise  = pin_rise[3];
  wire        tmr_rise  = pin_rise[4];
  wire [3:0]  pwm0_rise = pin_rise[8:5];
  wire [3:0]  pwm1_rise = pin_rise[12:9];
  wire [3:0]  dcmp_rise = pin_rise[16:13];
  wire [3:0]  dma_rise  = pin_rise[20:17];

  // ==========================================================
  // Processor trigger with cross-module wait/signal
  // ==========================================================
  reg  [3:0] proc_held_r;
  reg  [3:0] proc_fire;
  reg  [3:0] trig_hit;
  reg  [3:0] pwm_sel;
  reg  [3:0] src;
  integer    k;

  always @* begin
    proc_fire = 4'h0;
    trig_hit  = 4'h0;
    pwm_sel   = 4'h0;
    src       = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      src = i_trig_src[4*k +: 4];
      proc_fire[k] = (i_proc_trig[k] & ~i_proc_trig_wait) | (proc_held_r[k] & i_proc_sync_signal);
      pwm_sel = i_pwm_mod_sel[k] ? pwm1_rise : pwm0_rise;
      case (src)
        `ASTC_TRIG_PROC:   trig_hit[k] = proc_fire[k];
        `ASTC_TRIG_CMP0:   trig_hit[k] = cmp_rise[0];
        `ASTC_TRIG_CMP1:   trig_hit[k] = cmp_rise[1];
        `ASTC_TRIG_CMP2:   trig_hit[k] = cmp_rise[2];
        `ASTC_TRIG_EXT:    trig_hit[k] = ext_rise;
        `ASTC_TRIG_TIMER:  trig_hit[k] = tmr_rise;
        `ASTC_TRIG_PWM0:   trig_hit[k] = pwm_sel[0];
        `ASTC_TRIG_PWM1:   trig_hit[k] = pwm_sel[1];
        `ASTC_TRIG_PWM2:   trig_hit[k] = pwm_sel[2];
        `ASTC_TRIG_PWM3:   trig_hit[k] = pwm_sel[3];
        `ASTC_TRIG_ALWAYS: trig_hit[k] = 1'b1;
        default:           trig_hit[k] = 1'b0;
      endcase
      trig_hit[k] = trig_hit[k] & i_seq_enable[k];
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      proc_held_r <= 4'h0;
    end else begin
      proc_held_r <= (proc_held_r & ~{4{i_proc_sync_signal}}) |
                     (i_proc_trig & {4{i_proc_trig_wait}});
    end
  end

  // ==========================================================
  // Pending triggers, arbitration, phase delay, conversion
  // ==========================================================
  localparam ST_IDLE  = 3'b001;
  localparam ST_PHASE = 3'b010;
  localparam ST_CONV  = 3'b100;

  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [3:0] pend_r;
  reg  [5:0] phase_cnt_r;
  reg  [5:0] conv_cnt_r;
  reg  [3:0] samp_cnt_r;
  reg  [1:0] win_idx;
  reg  [1:0] win_prio;
  reg        win_ok;
  reg  [3:0] depth_of;
  integer    j;

  always @* begin
    win_idx  = 2'd0;
    win_prio = 2'd3;
    win_ok   = 1'b0;
    for (j = 0; j < 4; j = j + 1) begin
      if (pend_r[j] && (!win_ok || i_prio[2*j +: 2] < win_prio)) begin
        win_ok   = 1'b1;
        win_idx  = j[1:0];
        win_prio = i_prio[2*j +: 2];
      end
    end
  end

  always @* begin
    case (o_active_seq)
      2'd0:    depth_of = `ASTC_DEPTH0;
      2'd1:    depth_of = `ASTC_DEPTH1;
      2'd2:    depth_of = `ASTC_DEPTH2;
      default: depth_of = `ASTC_DEPTH3;
    endcase
  end

  wire [5:0] phase_target = {2'b00, i_phase_delay} * {1'b0, `ASTC_PHASE_STEP_CLKS};
  wire       conv_last    = (conv_cnt_r == `ASTC_CONV_CLKS - 6'd1);
  wire       seq_done     = conv_last && (samp_cnt_r == depth_of - 4'd1);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (win_ok) state_nxt = ST_PHASE;
      ST_PHASE: if (phase_cnt_r == phase_target) state_nxt = ST_CONV;
      ST_CONV:  if (seq_done) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  reg [3:0] seq_done_evt;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r        <= ST_IDLE;
      pend_r         <= 4'h0;
      phase_cnt_r    <= 6'h00;
      conv_cnt_r     <= 6'h00;
      samp_cnt_r     <= 4'h0;
      o_active_seq   <= 2'd0;
      o_active_depth <= 4'h0;
      o_conv_busy    <= 1'b0;
      o_seq_start    <= 4'h0;
      seq_done_evt   <= 4'h0;
    end else begin
      state_r      <= state_nxt;
      o_seq_start  <= 4'h0;
      seq_done_evt <= 4'h0;
      pend_r       <= pend_r | trig_hit;
      case (state_r)
        ST_IDLE: begin
          if (win_ok) begin
            phase_cnt_r  <= 6'h00;
            o_active_seq <= win_idx;
            pend_r[win_idx] <= trig_hit[win_idx];
          end
        end
        ST_PHASE: begin
          phase_cnt_r <= phase_cnt_r + 6'd1;
          if (phase_cnt_r == phase_target) begin
            o_seq_start[o_active_seq] <= 1'b1;
            o_active_depth <= depth_of;
            o_conv_busy    <= 1'b1;
            conv_cnt_r     <= 6'h00;
            samp_cnt_r     <= 4'h0;
          end
        end
        ST_CONV: begin
          conv_cnt_r <= conv_last ? 6'h00 : conv_cnt_r + 6'd1;
          if (conv_last) begin
            samp_cnt_r <= samp_cnt_r + 4'd1;
          end
          if (seq_done) begin
            o_conv_busy <= 1'b0;
            seq_done_evt[o_active_seq] <= 1'b1;
          end
        end
        default: begin
          o_conv_busy <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Settings readback and interrupt status
  // ==========================================================
  reg [3:0] dma_raw_r;
  reg [3:0] dcmp_raw_r;
  wire [19:0] raw_all = {dcmp_raw_r, 4'h0, dma_raw_r, 4'h0, o_int_raw};
  wire [19:0] en_all  = {i_dcmp_int_enable, 4'h0, i_dma_int_enable, 4'h0, i_int_enable};

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_phase_delay <= 4'h0;
      o_ref_sel     <= `ASTC_REF_INT;
      o_int_raw     <= 4'h0;
      o_int_masked  <= 4'h0;
      dma_raw_r     <= 4'h0;
      dcmp_raw_r    <= 4'h0;
      o_status      <= 20'h00000;
    end else begin
      o_phase_delay <= i_phase_delay;
      o_ref_sel     <= i_ref_sel;
      o_int_raw     <= (o_int_raw & ~i_int_clear) | seq_done_evt;
      dma_raw_r     <= (dma_raw_r & ~i_dma_int_clear) | dma_rise;
      dcmp_raw_r    <= (dcmp_raw_r & ~i_dcmp_int_clear) | dcmp_rise;
      o_int_masked  <= o_int_raw & i_int_enable;
      o_status      <= i_status_masked_select ? (raw_all & en_all) : raw_all;
    end
  end

  assign o_irq = |(raw_all & en_all);

endmodule

/* verilog/astc_consts.vh */
`ifndef ASTC_CONSTS_VH
`define ASTC_CONSTS_VH

// Trigger source encodings (4 bits)
`define ASTC_TRIG_PROC      4'h0
`define ASTC_TRIG_CMP0      4'h1
`define ASTC_TRIG_CMP1      4'h2
`define ASTC_TRIG_CMP2      4'h3
`define ASTC_TRIG_EXT       4'h4
`define ASTC_TRIG_TIMER     4'h5
`define ASTC_TRIG_PWM0      4'h6
`define ASTC_TRIG_PWM1      4'h7
`define ASTC_TRIG_PWM2      4'h8
`define ASTC_TRIG_PWM3      4'h9
`define ASTC_TRIG_ALWAYS    4'hf

// Sequencer depths
`define ASTC_DEPTH0         4'h8
`define ASTC_DEPTH1         4'h4
`define ASTC_DEPTH2         4'h4
`define ASTC_DEPTH3         4'h1

// Reference select
`define ASTC_REF_INT        1'b0
`define ASTC_REF_EXT        1'b1

// Phase delay: step is 1/16 of a sample period, measured in clocks
`define ASTC_PHASE_STEP_CLKS 5'h02
// Clocks taken by one conversion
`define ASTC_CONV_CLKS      6'h20

// Status field positions: [3:0] sequence, [11:8] dma, [19:16] comparator
`define ASTC_ST_SEQ_LSB     0
`define ASTC_ST_DMA_LSB     8
`define ASTC_ST_DCMP_LSB    16

`endif

/* verification/astc_src_model.sv */
`timescale 1ns/100ps
// ==========
// Trigger source pins
module astc_src_model (
  input  wire [12:0] i_fire,
  input  wire        i_clk,
  output wire [12:0] o_pins
);
  reg [12:0] d1_r;
  reg [12:0] d2_r;
  always @(posedge i_clk) begin
    d1_r <= i_fire;
    d2_r <= d1_r;
  end
  assign o_pins = i_fire | d1_r | d2_r;
endmodule

/* verification/astc_seq_ctrl_chk.sv */
`timescale 1ns/100ps
// ==========
// Port checks
module astc_chk (
  input logic        i_clk,
  input logic        i_rstn,
  input logic [3:0]  i_phase_delay,
  input logic [3:0]  i_int_enable,
  input logic [3:0]  i_int_clear,
  input logic        i_status_masked_select,
  input logic [3:0]  o_phase_delay,
  input logic [3:0]  o_int_raw,
  input logic [3:0]  o_int_masked,
  input logic [19:0] o_status,
  input logic        o_irq,
  input logic        o_conv_busy,
  input logic [3:0]  o_active_depth,
  input logic [3:0]  o_seq_start
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_start;
    o_seq_start != 4'h0 |-> $onehot(o_seq_start) && o_conv_busy;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_depth;
    o_seq_start != 4'h0 |->
      o_active_depth == (o_seq_start[0] ? 4'h8 : (o_seq_start[3] ? 4'h1 : 4'h4));
  endproperty
  a_depth: assert property (p_depth) else $error("bad depth");
  property p_short;
    $rose(o_conv_busy) && o_active_depth == 4'h1 |->
      o_conv_busy [*8] ##24 o_conv_busy ##1 !o_conv_busy;
  endproperty
  a_short: assert property (p_short) else $error("bad busy");
  property p_phase;
    $stable(i_phase_delay) [*3] |-> o_phase_delay == i_phase_delay;
  endproperty
  a_phase: assert property (p_phase) else $error("bad phase");
  property p_mask;
    $stable(o_int_raw & i_int_enable) [*2] |-> o_int_masked == (o_int_raw & i_int_enable);
  endproperty
  a_mask: assert property (p_mask) else $error("bad mask");
  property p_irq;
    (o_int_raw & i_int_enable) != 4'h0 |-> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_sticky;
    (o_int_raw & ~i_int_clear) != 4'h0 |=>
      (o_int_raw & $past(o_int_raw & ~i_int_clear)) == $past(o_int_raw & ~i_int_clear);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_raw;
    (!i_status_masked_select && $stable(o_int_raw)) [*3] |-> o_status[3:0] == o_int_raw;
  endproperty
  a_raw: assert property (p_raw) else $error("bad status");
  c_long: cover property ($rose(o_conv_busy) && o_active_depth == 4'h8);
  c_irq: cover property (o_irq);
  c_msk: cover property (i_status_masked_select && o_status != 20'h0);
endmodule
bind astc_seq_ctrl astc_chk u_chk (.i_clk, .i_rstn, .i_phase_delay, .i_int_enable,
  .i_int_clear, .i_status_masked_select, .o_phase_delay, .o_int_raw, .o_int_masked,
  .o_status, .o_irq, .o_conv_busy, .o_active_depth, .o_seq_start);

/* verification/testbench.sv */
`timescale 1ns/100ps
// ==========
// Bench
module testbench;
  logic        i_clk = 0, i_rstn = 0, i_ref_sel = 0, i_proc_trig_wait = 0;
  logic        i_proc_sync_signal = 0, i_status_masked_select = 0;
  logic [15:0] i_trig_src = 16'heeee;
  logic [7:0]  i_prio = 8'he4;
  logic [3:0]  i_pwm_mod_sel = 0, i_seq_enable = 4'hf, i_phase_delay = 0, i_int_enable = 0;
  logic [3:0]  i_dma_int_enable = 0, i_dcmp_int_enable = 0, i_int_clear = 0;
  logic [3:0]  i_dma_int_clear = 0, i_dcmp_int_clear = 0, i_proc_trig = 0;
  logic [3:0]  i_dma_event = 0, i_dcmp_event = 0;
  logic [12:0] fire = 0;
  wire  [12:0] pins;
  wire  [3:0]  o_phase_delay, o_int_raw, o_int_masked, o_active_depth, o_seq_start;
  wire  [19:0] o_status;
  wire  [1:0]  o_active_seq;
  wire         o_ref_sel, o_irq, o_conv_busy;
  int          err_count = 0, compares = 0, cyc = 0, n, n0;
  astc_src_model src_m (.i_clk, .i_fire(fire), .o_pins(pins));
  astc_seq_ctrl uut (.i_clk, .i_rstn, .i_trig_src, .i_pwm_mod_sel, .i_prio, .i_seq_enable,
    .i_phase_delay, .i_ref_sel, .i_int_enable, .i_dma_int_enable, .i_dcmp_int_enable,
    .i_int_clear, .i_dma_int_clear, .i_dcmp_int_clear, .i_proc_trig, .i_proc_trig_wait,
    .i_proc_sync_signal, .i_status_masked_select, .i_cmp_trig(pins[2:0]),
    .i_ext_trig(pins[3]), .i_timer_trig(pins[4]), .i_pwm_mod0_trig(pins[8:5]),
    .i_pwm_mod1_trig(pins[12:9]), .i_dma_event, .i_dcmp_event, .o_phase_delay, .o_ref_sel,
    .o_int_raw, .o_int_masked, .o_status, .o_irq, .o_conv_busy, .o_active_seq,
    .o_active_depth, .o_seq_start);
  initial forever #25 i_clk = ~i_clk;
  task automatic tk(input int k = 1);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic trig(input logic [3:0] v, input logic w);
    i_proc_trig = v;
    i_proc_trig_wait = w;
    tk();
    i_proc_trig = 4'h0;
    i_proc_trig_wait = 1'b0;
  endtask
  task automatic fp(input int i);
    fire[i] = 1'b1;
    tk();
    fire = 13'h0;
  endtask
  task automatic wst(input logic [3:0] e, input int lim);
    n = 0;
    while (o_seq_start === 4'h0 && n < lim) begin
      tk();
      n++;
    end
    chk(o_seq_start, e);
  endtask
  task automatic wdone(input logic [3:0] m);
    int j;
    j = 0;
    while ((o_int_raw & m) !== m && j < 700) begin
      tk();
      j++;
    end
    chk(o_int_raw & m, m);
  endtask
  task automatic clr(input logic [3:0] m);
    i_int_clear = m;
    tk();
    i_int_clear = 4'h0;
    tk();
    chk(o_int_raw & m, 4'h0);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 30000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    tk(16);
    i_rstn = 1'b1;
    chk(o_ref_sel, 1'b0);
    i_phase_delay = 4'h9;
    i_ref_sel = 1'b1;
    tk(3);
    chk(o_phase_delay, 4'h9);
    chk(o_ref_sel, 1'b1);
    i_phase_delay = 4'h0;
    i_int_enable = 4'h2;
    i_trig_src = 16'hee0e;
    tk(3);
    trig(4'h2, 1'b0);
    wst(4'h2, 300);
    n0 = n;
    wdone(4'h2);
    chk(o_irq, 1'b1);
    tk();
    chk(o_int_masked, 4'h2);
    i_int_enable = 4'h0;
    tk();
    chk(o_irq, 1'b0);
    chk(o_int_raw, 4'h2);
    chk(o_int_masked, 4'h0);
    clr(4'h2);
    // Each phase step adds two clocks
    i_phase_delay = 4'h5;
    tk(3);
    trig(4'h2, 1'b0);
    wst(4'h2, 300);
    chk(n - n0, 10);
    wdone(4'h2);
    clr(4'h2);
    // Half-period step, as used when pairing two modules
    i_phase_delay = 4'h8;
    tk(3);
    trig(4'h2, 1'b0);
    wst(4'h2, 300);
    chk(n - n0, 16);
    wdone(4'h2);
    clr(4'h2);
    i_phase_delay = 4'h0;
    i_trig_src = 16'hee5e;
    trig(4'h2, 1'b0);
    wst(4'h0, 20);
    i_trig_src = 16'hee0e;
    trig(4'h2, 1'b1);
    wst(4'h0, 20);
    i_proc_sync_signal = 1'b1;
    tk();
    i_proc_sync_signal = 1'b0;
    wst(4'h2, 300);
    wdone(4'h2);
    clr(4'h2);
    i_trig_src = 16'he0e0;
    i_prio = 8'h87;
    trig(4'h5, 1'b0);
    wst(4'h4, 300);
    chk(o_active_seq, 2'd2);
    wdone(4'h4);
    wst(4'h1, 300);
    chk(o_active_seq, 2'd0);
    wdone(4'h1);
    clr(4'h5);
    i_prio = 8'he4;
    i_pwm_mod_sel = 4'h8;
    for (int c = 1; c < 10; c++) begin
      i_trig_src = {c[3:0], 12'heee};
      tk();
      if (c > 5) begin
        fp(c - 1);
        wst(4'h0, 20);
      end
      fp(c > 5 ? c + 3 : c - 1);
      wst(4'h8, 300);
      chk(o_active_depth, 4'h1);
      wdone(4'h8);
      clr(4'h8);
    end
    i_trig_src = 16'hfee0;
    wst(4'h8, 300);
    tk();
    wst(4'h8, 60);
    trig(4'h1, 1'b0);
    wst(4'h1, 300);
    i_trig_src = 16'heee0;
    wdone(4'h9);
    clr(4'h9);
    i_dma_event = 4'h1;
    i_dcmp_event = 4'h2;
    tk();
    i_dma_event = 4'h0;
    i_dcmp_event = 4'h0;
    tk(6);
    chk(o_status, 20'h20100);
    i_status_masked_select = 1'b1;
    tk(3);
    chk(o_status, 20'h0);
    i_dma_int_enable = 4'h1;
    tk(3);
    chk(o_status, 20'h00100);
    chk(o_irq, 1'b1);
    i_dma_int_clear = 4'h1;
    i_dcmp_int_clear = 4'h2;
    tk();
    i_dma_int_clear = 4'h0;
    i_dcmp_int_clear = 4'h0;
    tk(3);
    chk(o_irq, 1'b0);
    end_sim();
  end
endmodule
